/* File: src/lockin_ref_defs.vh */
`ifndef LOCKIN_REF_DEFS_VH
`define LOCKIN_REF_DEFS_VH
// Register byte addresses
`define A_CTRL    6'h00
`define A_PHASE   6'h04
`define A_CMD     6'h08
`define A_FREQ    6'h0C
`define A_START   6'h10
`define A_STOP    6'h14
`define A_STEP    6'h18
`define A_RATIO   6'h1C
`define A_SCANLEN 6'h20
`define A_HARM    6'h24
`define A_AMPL    6'h28
`define A_STATUS  6'h2C
`define A_CURFREQ 6'h30
// Sources and discriminator modes
`define SRC_INT   2'h0
`define SRC_SWEEP 2'h1
`define SRC_EXT   2'h2
`define SLP_RISE  2'h0
`define SLP_FALL  2'h1
`define SLP_SINE  2'h2
// Phase in millidegrees
`define PH_MAX    20'sh2BF20
`define PH_MIN    -20'sh2BF20
`define PH_FULL   20'sh57E40
`define PH_ROT    20'sh15F90
// Millidegree to 2^32 phase, scaled by 2^8
`define OFF_MUL   23'h2E9A77
// Frequency in 0.1 mHz units
`define F_MIN     30'h0000000A
`define F_MAX     30'h3CCBF700
`define F_DEF     30'h00989680
`define F_STOP    30'h01312D00
// 0.1 mHz units->NCO step: (f * INC_MUL) >> 32 at 250 MHz
`define INC_MUL   24'h70970A
// Lock limits at 250 MHz: rates in Hz, longest period in clocks
`define CLK_HZ    40'h000EE6B280
`define LIM_HZ    40'h0000018E70
`define PER_MAX   40'h3A35294400
// Reset values and amplitude limits
`define HARM_DEF  15'h0001
`define AMPL_DEF  13'h03E8
`define AMPL_MIN  13'h0004
`define AMPL_MAX  13'h1388
`define RATIO_ONE 32'h01000000
`define SLEN_DEF  16'h3E80
`endif

/* File: src/lockin_ref_gen.v */
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "lockin_ref_defs.vh"
// Function
// R1 - Phase offset held in millidegrees, limited to -180 to +180 degrees.
// R2 - Numeric phase entries round to the nearest millidegree step.
// R3 - Rotate command adds exactly ninety degrees to the phase offset.
// R4 - Rotate or auto-phase results wrap back by 360 degrees into range.
// R5 - Offset shifts only detection sines; sine output and magnitude stay unshifted.
// R6 - Auto-phase subtracts measured phase from offset, moving phase toward zero.
// R7 - Sources: fixed internal, internal sweep, external reference input.
// R8 - External lock from 0.001 Hz to 102 kHz divided by harmonic.
// R9 - Discriminator choice only under external source: rise, fall, sine.
// R10 - Logic-level modes lock to the chosen edge of the reference.
// R11 - Sine mode locks to rising zero crossings of the reference.
// R12 - Below 1 Hz the outside source must supply a logic-level reference.
// R13 - Internal sources use the synthesiser and ignore the reference input.
// R14 - Frequency setting accepted only under fixed internal source.
// R15 - Internal frequency limited 0.001 Hz to 102 kHz divided by harmonic.
// R16 - Sweep steps once per stored sample, start to stop over one scan.
// R17 - Scan pause freezes sweep; scan reset returns to start frequency.
// R18 - Sweep linear or exponential, independent start and stop, either direction.
// R19 - Exponential sweep multiplies by constant ratio reaching stop at last sample.
// R20 - Detection at N times reference, N up to 32767, within 102 kHz.
// R21 - Sine output amplitude settable from 4 mVrms to 5 Vrms.
// R22 - Sine output stays generated and locked to an external reference.
// R23 - Sync square from sine zero crossings, locked in all modes.
// R24 - Reset restores phase 0, internal, sine, N=1, 1 Vrms, 1 kHz sweep.
module lockin_ref_gen (
   // Clock and reset
   input  wire        clock,
   input  wire        rst,
   // Avalon-MM slave
   input  wire [5:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [31:0] writedata,
   output wire        waitrequest,
   output reg  [31:0] readdata,
   // Reference input pins
   input  wire        ref_ttl,
   input  wire        ref_sine_pos,
   // Detector and scan interface
   input  wire [19:0] meas_phase,
   input  wire        scan_sample,
   input  wire        scan_pause,
   input  wire        scan_reset,
   // Reference outputs
   output reg  [31:0] ref_phase,
   output reg  [31:0] det_phase,
   output reg         sync_out,
   output reg  [12:0] sine_ampl,
   output reg         locked
);

   // ******************************************
   // Registers
   // ******************************************
   reg        [1:0]  src_q;
   reg        [1:0]  slope_q;
   reg               exp_q;
   reg signed [19:0] phase_q;
   reg signed [19:0] phase_d;
   reg        [29:0] freq_q;
   reg        [29:0] start_q;
   reg        [29:0] stop_q;
   reg signed [30:0] step_q;
   reg        [31:0] ratio_q;
   reg        [15:0] slen_q;
   reg        [14:0] harm_q;
   reg        [29:0] cur_q;
   reg        [15:0] cnt_q;
   reg               ferr_q;
   reg               ack_q;

   // Each request takes two clocks: waitrequest high on the first, low on the second
   // Writes land at the edge where waitrequest is seen low, never earlier
   wire acc_wr = write && ack_q;
   // Read data is loaded on the first clock so it stands when waitrequest drops
   wire acc_rd = read && !ack_q;
   assign waitrequest = (read || write) && !ack_q;

   // Frequency times harmonic must stay at or under the top limit
   wire [44:0] fn_w  = writedata[29:0] * harm_q;
   wire [44:0] fn_cur = freq_q * writedata[14:0];
   wire f_ok = (fn_w <= {15'h0000, `F_MAX}) && (writedata[29:0] >= `F_MIN); // [R15]
   wire n_ok = (writedata[14:0] != 15'h0000) &&
               (fn_cur <= {15'h0000, `F_MAX}); // [R20]

   // ******************************************
   // Phase offset arithmetic
   // ******************************************
   // Whole word is compared, so a large entry clamps instead of wrapping
   wire signed [31:0] wr_ph = writedata;
   reg  signed [20:0] ph_t;
   always @* begin
      phase_d = phase_q;
      ph_t    = 21'sh0;
      if (acc_wr && address == `A_PHASE) begin
         // Entry is already in whole millidegrees, so no finer part remains
         if (wr_ph > `PH_MAX)
            phase_d = `PH_MAX; // [R1] [R2]
         else if (wr_ph < `PH_MIN)
            phase_d = `PH_MIN; // [R1]
         else
            phase_d = wr_ph[19:0];
      end else if (acc_wr && address == `A_CMD && (writedata[0] || writedata[1])) begin
         // Rotate wins when both command bits are set
         if (writedata[0])
            ph_t = phase_q + `PH_ROT; // [R3]
         else
            ph_t = phase_q - $signed(meas_phase); // [R6]
         if (ph_t > `PH_MAX)
            phase_d = ph_t[19:0] - `PH_FULL; // [R4]
         else if (ph_t < `PH_MIN)
            phase_d = ph_t[19:0] + `PH_FULL; // [R4]
         else
            phase_d = ph_t[19:0];
      end
   end

   // ******************************************
   // Register writes and sweep
   // ******************************************
   wire [61:0] exp_prod = cur_q * ratio_q;
   wire        sweeping = (src_q == `SRC_SWEEP);
   // Sample numbered SCANLEN-1 pins the frequency to stop
   wire        last     = (cnt_q + 16'h0001 >= slen_q);

   always @(posedge clock) begin
      if (rst) begin
         // Power-up defaults of the reference settings
         src_q   <= `SRC_INT; // [R24]
         slope_q <= `SLP_SINE;
         exp_q   <= 1'b0;
         phase_q <= 20'sh0;
         freq_q  <= `F_DEF;
         start_q <= `F_DEF;
         stop_q  <= `F_STOP;
         step_q  <= 31'sh0;
         ratio_q <= `RATIO_ONE;
         slen_q  <= `SLEN_DEF;
         harm_q  <= `HARM_DEF;
         sine_ampl <= `AMPL_DEF;
         cur_q   <= `F_DEF;
         cnt_q   <= 16'h0000;
         ferr_q  <= 1'b0;
         ack_q   <= 1'b0;
      end else begin
         ack_q   <= (read || write) && !ack_q;
         phase_q <= phase_d;
         if (acc_wr) begin
            case (address)
               `A_CTRL: begin
                  if (writedata[1:0] <= `SRC_EXT)
                     src_q <= writedata[1:0]; // [R7]
                  if (writedata[1:0] == `SRC_EXT && writedata[3:2] <= `SLP_SINE)
                     slope_q <= writedata[3:2]; // [R9]
                  exp_q <= writedata[4]; // [R18]
               end
               `A_FREQ: begin
                  if (src_q == `SRC_INT && f_ok)
                     freq_q <= writedata[29:0]; // [R14] [R15]
                  // Error flag reflects only the latest frequency or harmonic write
                  ferr_q <= !(src_q == `SRC_INT && f_ok);
               end
               `A_START: start_q <= writedata[29:0]; // [R18]
               `A_STOP:  stop_q  <= writedata[29:0]; // [R18]
               `A_STEP:  step_q  <= writedata[30:0];
               `A_RATIO: ratio_q <= writedata; // [R19]
               `A_SCANLEN: slen_q <= writedata[15:0];
               `A_HARM: begin
                  if (n_ok)
                     harm_q <= writedata[14:0]; // [R20]
                  ferr_q <= !n_ok;
               end
               `A_AMPL: begin
                  // Any upper bit set is far above the top, so clamp high first
                  if (writedata[31:13] != 19'h0 || writedata[12:0] > `AMPL_MAX)
                     sine_ampl <= `AMPL_MAX; // [R21]
                  else if (writedata[12:0] < `AMPL_MIN)
                     sine_ampl <= `AMPL_MIN; // [R21]
                  else
                     sine_ampl <= writedata[12:0];
               end
               default: ;
            endcase
         end
         // Synthesiser frequency: fixed setting or sweep position
         if (!sweeping) begin
            // Sweep is parked at the fixed setting while another source runs
            cur_q <= freq_q;
            cnt_q <= 16'h0000;
         end else if (scan_reset) begin
            cur_q <= start_q; // [R17]
            cnt_q <= 16'h0000;
         end else if (scan_sample && !scan_pause) begin // [R16] [R17]
            if (last) begin
               // Land exactly on stop so rounding in step or ratio never drifts
               cur_q <= stop_q;
            end else begin
               cnt_q <= cnt_q + 16'h0001;
               if (exp_q)
                  cur_q <= exp_prod[53:24]; // [R19]
               else
                  cur_q <= cur_q + step_q[29:0]; // [R18]
            end
         end
      end
   end

   // ******************************************
   // Reference input capture
   // ******************************************
   // Two stages before any logic reads the pins; the third flop only keeps
   // the last synchronised level for edge detection
   reg  [1:0] ttl_s;
   reg  [1:0] sin_s;
   reg        ttl_p;
   reg        sin_p;
   always @(posedge clock) begin
      if (rst) begin
         ttl_s <= 2'b00;
         sin_s <= 2'b00;
         ttl_p <= 1'b0;
         sin_p <= 1'b0;
      end else begin
         ttl_s <= {ttl_s[0], ref_ttl};
         sin_s <= {sin_s[0], ref_sine_pos};
         ttl_p <= ttl_s[1];
         sin_p <= sin_s[1];
      end
   end

   reg ext_edge;
   always @* begin
      case (slope_q)
         `SLP_RISE: ext_edge = ttl_s[1] && !ttl_p; // [R10]
         `SLP_FALL: ext_edge = !ttl_s[1] && ttl_p; // [R10]
         `SLP_SINE: ext_edge = sin_s[1] && !sin_p; // [R11]
         default:   ext_edge = 1'b0;
      endcase
   end
   // Edges only count under the external source
   wire ext_on = (src_q == `SRC_EXT);
   wire edge_v = ext_on && ext_edge; // [R13]

   // ******************************************
   // Period measurement and serial divide
   // ******************************************
   // A slow reference must be logic-level; the sine path is not usable there [R12]
   reg  [39:0] per_q;
   reg  [39:0] div_d_q;
   reg  [40:0] rem_q;
   reg  [31:0] quo_q;
   reg  [5:0]  dcnt_q;
   reg         busy_q;
   reg  [31:0] ext_inc_q;
   reg         seen_q;
   wire [40:0] rem_sh = {rem_q[39:0], 1'b0};
   // Band test without a divide: period * limit >= clock rate * harmonic
   wire [79:0] lim_l  = per_q * `LIM_HZ;
   wire [54:0] lim_r  = `CLK_HZ * harm_q;

   always @(posedge clock) begin
      if (rst) begin
         per_q     <= 40'h0;
         div_d_q   <= 40'h0;
         rem_q     <= 41'h0;
         quo_q     <= 32'h0;
         dcnt_q    <= 6'h00;
         busy_q    <= 1'b0;
         ext_inc_q <= 32'h0;
         seen_q    <= 1'b0;
         locked    <= 1'b0;
      end else begin
         if (!ext_on) begin
            per_q  <= 40'h0;
            seen_q <= 1'b0;
            locked <= 1'b0;
         end else if (edge_v) begin
            per_q  <= 40'h1;
            seen_q <= 1'b1;
            // Lock valid only inside the band scaled by the harmonic
            locked <= seen_q && (lim_l >= {25'h0000000, lim_r}); // [R8]
            // An edge arriving mid-divide is skipped; the next period updates the step
            if (seen_q && !busy_q) begin
               div_d_q <= per_q;
               rem_q   <= 41'h1;
               quo_q   <= 32'h0;
               dcnt_q  <= 6'h20;
               busy_q  <= 1'b1;
            end
         end else if (per_q >= `PER_MAX) begin
            // Slower than the lowest lockable rate
            locked <= 1'b0; // [R8]
            seen_q <= 1'b0;
         end else begin
            per_q <= per_q + 40'h1;
         end
         // 2^32 / period: one quotient bit per clock, 32 clocks per update
         if (busy_q) begin
            if (rem_sh >= {1'b0, div_d_q}) begin
               rem_q <= rem_sh - {1'b0, div_d_q};
               quo_q <= {quo_q[30:0], 1'b1};
            end else begin
               rem_q <= rem_sh;
               quo_q <= {quo_q[30:0], 1'b0};
            end
            dcnt_q <= dcnt_q - 6'h01;
            if (dcnt_q == 6'h01)
               busy_q <= 1'b0;
         end else if (dcnt_q == 6'h00 && quo_q != 32'h0) begin
            // Zero quotient means no period yet, so the old step is kept
            ext_inc_q <= quo_q;
         end
      end
   end

   // ******************************************
   // Oscillator and outputs
   // ******************************************
   wire [53:0] int_prod = cur_q * `INC_MUL;
   // Internal step is (f * INC_MUL) >> 32 with the top ten bits clear; the external source uses the measured step ext_inc_q
   wire [31:0] inc      = ext_on ? ext_inc_q : {10'h000, int_prod[53:32]};
   // Signed product so negative offsets turn the detection phase backwards
   wire signed [43:0] off_prod = phase_q * $signed({1'b0, `OFF_MUL});
   wire [46:0] harm_ph  = ref_phase * harm_q;
   reg  [31:0] acc_q;

   always @(posedge clock) begin
      if (rst) begin
         acc_q     <= 32'h0;
         ref_phase <= 32'h0;
         det_phase <= 32'h0;
         sync_out  <= 1'b0;
      end else begin
         // External edge realigns the sine to the reference [R22]
         if (edge_v)
            acc_q <= 32'h0;
         else
            acc_q <= acc_q + inc;
         ref_phase <= acc_q; // [R5] [R22]
         det_phase <= harm_ph[31:0] + off_prod[39:8]; // [R5] [R20]
         // Sync follows the sine phase one clock later
         sync_out  <= (ref_phase < 32'h80000000); // [R23]
      end
   end

   // ******************************************
   // Register reads
   // ******************************************
   always @(posedge clock) begin
      if (rst) begin
         readdata <= 32'h0;
      end else if (acc_rd) begin
         // Only the first clock of a read loads, so the word holds until the next read
         case (address)
            `A_CTRL:    readdata <= {27'h0, exp_q, slope_q, src_q};
            `A_PHASE:   readdata <= {{12{phase_q[19]}}, phase_q};
            `A_FREQ:    readdata <= {2'h0, freq_q};
            `A_START:   readdata <= {2'h0, start_q};
            `A_STOP:    readdata <= {2'h0, stop_q};
            `A_STEP:    readdata <= {step_q[30], step_q};
            `A_RATIO:   readdata <= ratio_q;
            `A_SCANLEN: readdata <= {16'h0, slen_q};
            `A_HARM:    readdata <= {17'h0, harm_q};
            `A_AMPL:    readdata <= {19'h0, sine_ampl};
            `A_STATUS:  readdata <= {30'h0, ferr_q, locked};
            `A_CURFREQ: readdata <= {2'h0, cur_q};
            default:    readdata <= 32'h0;
         endcase
      end
   end

endmodule

/* File: sim/ref_source_model.sv */
`timescale 1ns/1ps
// ********
// External reference source
// ********
module ref_source_model (
   // Bench control
   input  wire logic run,
   input  int        half_ns,
   // Reference pins
   output logic      ref_ttl,
   output logic      ref_sine_pos
);
   initial begin
      ref_ttl = 1'h0;
      ref_sine_pos = 1'h0;
   end
   // Always a logic-level square, so slow rates never need the sine path
   always begin
      wait (run);
      #(half_ns) ref_ttl = ~ref_ttl;
   end
   // Comparator lags a quarter period so the two modes give distinct phases
   always @(ref_ttl) begin
      ref_sine_pos <= #(half_ns / 2) ref_ttl;
   end
endmodule

/* File: sim/lockin_ref_gen_checker.sv */
`timescale 1ns/1ps
`include "lockin_ref_defs.vh"
// ********
// Port checker
// ********
module lockin_ref_gen_checker (
   // Clock and bus
   input wire        clock,
   input wire        rst,
   input wire [5:0]  address,
   input wire        read,
   input wire        write,
   input wire [31:0] writedata,
   input wire        waitrequest,
   input wire [31:0] readdata,
   // Outputs
   input wire [31:0] ref_phase,
   input wire        sync_out,
   input wire [12:0] sine_ampl,
   input wire        locked
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   wire req = read || write;
   a_wait_first: assert property (req && !$past(req) |-> waitrequest)
      else $error("request answered in its first cycle");
   a_wait_once: assert property (req && waitrequest |=> !waitrequest)
      else $error("waitrequest held past one cycle");
   a_rdata_hold: assert property ($changed(readdata) |-> $past(read))
      else $error("readdata changed without a read");
   a_unmapped_zero: assert property (read && !waitrequest && address > 6'h30 |-> readdata == 0)
      else $error("unmapped read not zero");
   a_ampl_set: assert property (write && !waitrequest && address == `A_AMPL |=>
      sine_ampl == ($past(writedata) < `AMPL_MIN ? `AMPL_MIN :
      $past(writedata) > `AMPL_MAX ? `AMPL_MAX : $past(writedata[12:0])))
      else $error("amplitude not taken from write");
   a_ampl_range: assert property (sine_ampl >= `AMPL_MIN && sine_ampl <= `AMPL_MAX)
      else $error("amplitude out of range");
   a_sync_rise: assert property ($rose(sync_out) |-> !ref_phase[31])
      else $error("sync rose in second half cycle");
   a_sync_fall: assert property ($fell(sync_out) |-> ref_phase[31])
      else $error("sync fell in first half cycle");
   c_lock: cover property ($rose(locked));
   c_sync: cover property ($rose(sync_out));
   c_ampl: cover property (write && !waitrequest && address == `A_AMPL);
endmodule
bind lockin_ref_gen lockin_ref_gen_checker u_chk (.clock, .rst, .address, .read, .write,
   .writedata, .waitrequest, .readdata, .ref_phase, .sync_out, .sine_ampl, .locked);

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`include "lockin_ref_defs.vh"
module tb_top;
   logic        clock = 1'h0;
   logic        rst = 1'h1;
   logic [5:0]  address = 6'h00;
   logic        read = 1'h0;
   logic        write = 1'h0;
   logic [31:0] writedata = 32'h0;
   logic [19:0] meas_phase = 20'h0;
   logic        scan_sample = 1'h0;
   logic        scan_pause = 1'h0;
   logic        scan_reset = 1'h0;
   logic        run = 1'h0;
   int          half_ns = 32;
   wire         waitrequest, ref_ttl, ref_sine_pos, sync_out, locked;
   wire  [31:0] readdata, ref_phase, det_phase;
   wire  [12:0] sine_ampl;
   int          fails = 0, compares = 0, cycles = 0, p, m, t;
   logic [31:0] q;
   logic [5:0]  da [9] = '{`A_CTRL, `A_PHASE, `A_FREQ, `A_START, `A_STOP, `A_HARM,
                           `A_AMPL, `A_STATUS, 6'h3C};
   logic [31:0] dv [9] = '{32'h8, 32'h0, 32'h989680, 32'h989680, 32'h1312D00, 32'h1,
                           32'h3E8, 32'h0, 32'h0};
   logic [31:0] cw [4] = '{32'h7, 32'h5, 32'h6, 32'h0};
   logic [31:0] ce [4] = '{32'h8, 32'h9, 32'h6, 32'h4};
   lockin_ref_gen u_dut (.clock, .rst, .address, .read, .write, .writedata, .waitrequest,
      .readdata, .ref_ttl, .ref_sine_pos, .meas_phase, .scan_sample, .scan_pause,
      .scan_reset, .ref_phase, .det_phase, .sync_out, .sine_ampl, .locked);
   ref_source_model u_src (.run, .half_ns, .ref_ttl, .ref_sine_pos);
   always #2 clock = ~clock;
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         fails++;
         tally_and_finish();
      end
   end
   // ********
   // Bus and check helpers
   // ********
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", s, e, g);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clock);
   endtask
   // Request holds until waitrequest is seen low at an edge
   task automatic bus(logic we, logic [5:0] a, logic [31:0] d);
      address <= a;
      writedata <= d;
      write <= we;
      read <= !we;
      @(posedge clock);
      while (waitrequest !== 1'h0) @(posedge clock);
      q = readdata;
      write <= 1'h0;
      read <= 1'h0;
      @(posedge clock);
   endtask
   task automatic rc(string s, logic [5:0] a, logic [31:0] e);
      bus(0, a, 0);
      chk(s, e, q);
   endtask
   task automatic ph(int v);
      bus(0, `A_PHASE, 0);
      chk("phase", v & 32'hFFFFF, q & 32'hFFFFF);
   endtask
   function automatic int wrap(int v);
      return v > `PH_MAX ? v - `PH_FULL : v < `PH_MIN ? v + `PH_FULL : v;
   endfunction
   function automatic logic [31:0] ampl(int v);
      return v < `AMPL_MIN ? `AMPL_MIN : v > `AMPL_MAX ? `AMPL_MAX : v;
   endfunction
   task automatic sweep(logic [31:0] c, logic [31:0] st, logic [31:0] sp,
                        logic [31:0] inc, int n);
      logic [31:0] e;
      int k;
      bus(1, `A_CTRL, c);
      bus(1, `A_START, st);
      bus(1, `A_STOP, sp);
      bus(1, c[4] ? `A_RATIO : `A_STEP, inc);
      bus(1, `A_SCANLEN, n);
      scan_reset <= 1'h1;
      tick(1);
      scan_reset <= 1'h0;
      tick(2);
      k = 0;
      for (int i = 0; i <= n + 1; i++) begin
         e = k >= n - 1 ? sp : c[4] ? st << k : st + k * inc;
         rc("sweep freq", `A_CURFREQ, e);
         scan_pause <= i == 1;
         scan_sample <= 1'h1;
         tick(1);
         scan_sample <= 1'h0;
         k += i != 1;
         tick(2);
      end
   endtask
   task automatic tally_and_finish;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ********
   // Main sequence
   // ********
   initial begin
      q = $urandom(32'h242BF671);
      tick(12);
      rst <= 1'h0;
      tick(1);
      foreach (da[i]) rc("default", da[i], dv[i]);
      foreach (cw[i]) begin
         bus(1, `A_CTRL, cw[i]);
         rc("ctrl", `A_CTRL, ce[i]);
      end
      $display("register test done");
      for (int i = 0; i < 8; i++) begin
         p = i == 0 ? `PH_MAX : $urandom_range(`PH_FULL) - `PH_MAX;
         m = $urandom_range(`PH_FULL) - `PH_MAX;
         meas_phase <= m[19:0];
         bus(1, `A_PHASE, p);
         ph(p);
         bus(1, `A_CMD, i == 1 ? 3 : 1);
         p = wrap(p + `PH_ROT);
         ph(p);
         bus(1, `A_CMD, 2);
         p = wrap(p - m);
         ph(p);
      end
      bus(1, `A_PHASE, -250000);
      ph(`PH_MIN);
      bus(1, `A_PHASE, 32'h100000);
      ph(`PH_MAX);
      for (int i = 0; i < 6; i++) begin
         p = i == 0 ? 0 : i == 1 ? 5001 : i == 2 ? 32'h2001 : $urandom_range(6000);
         bus(1, `A_AMPL, p);
         chk("ampl", ampl(p), sine_ampl);
      end
      $display("phase test done");
      bus(1, `A_FREQ, 5);
      rc("status", `A_STATUS, 32'h2);
      bus(1, `A_FREQ, 32'hF4240);
      rc("status", `A_STATUS, 32'h0);
      bus(1, `A_FREQ, 32'h3CCBF701);
      bus(1, `A_HARM, 0);
      bus(1, `A_HARM, 32'h7FFF);
      rc("freq", `A_FREQ, 32'hF4240);
      rc("harm", `A_HARM, 32'h1);
      bus(1, `A_HARM, 32'h3FC);
      rc("harm", `A_HARM, 32'h3FC);
      bus(1, `A_FREQ, 32'hF4241);
      rc("freq", `A_FREQ, 32'hF4240);
      bus(1, `A_HARM, 3);
      bus(1, `A_FREQ, 32'h0EE6B280);
      bus(1, `A_PHASE, `PH_ROT);
      run <= 1'h1;
      tick(20);
      q = det_phase - 3 * ref_phase - 32'h40000000 + 32'h1000000;
      chk("det offset", 1, q < 32'h2000000);
      @(posedge sync_out);
      t = cycles;
      @(posedge sync_out);
      chk("sync period", 1, cycles - t > 9997 && cycles - t < 10003);
      chk("locked", 0, locked);
      tick(1);
      bus(1, `A_HARM, 1);
      bus(1, `A_PHASE, 0);
      $display("internal test done");
      p = $urandom_range(2000000, 1000000);
      m = $urandom_range(1000, 1);
      sweep(32'h1, p, p + 4 * m, m, 5);
      sweep(32'h1, p, p - 5 * m, -m, 6);
      sweep(32'h11, m * 20, m * 160, 32'h2000000, 4);
      bus(1, `A_FREQ, 32'h200000);
      rc("freq", `A_FREQ, 32'h0EE6B280);
      $display("sweep test done");
      half_ns = 5000;
      for (int i = 0; i < 3; i++) begin
         bus(1, `A_CTRL, 32'h2 | i << 2);
         tick(8000);
         chk("locked", 1, locked);
         if (i == 0) @(posedge ref_ttl);
         if (i == 1) @(negedge ref_ttl);
         if (i == 2) @(posedge ref_sine_pos);
         tick(12);
         chk("edge phase", 0, ref_phase[31:28]);
         chk("sync", 1, sync_out);
      end
      bus(1, `A_HARM, 2);
      tick(8000);
      chk("locked", 0, locked);
      bus(1, `A_HARM, 1);
      half_ns = 32;
      tick(8000);
      chk("locked", 0, locked);
      $display("external test done");
      run <= 1'h0;
      tally_and_finish();
   end
endmodule
